// ---- shared/prc_pkg.sv ----
package prc_pkg;
  // Clock and pin timing
  localparam int CLK_MHZ     = 100;
  localparam int T_STROBE_NS = 30;
  localparam int T_RESET_NS  = 100;
  localparam int STROBE_CYC  = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_CYC   = (T_RESET_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W       = 8;

  // Register offsets on the AXI4-Lite side
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_CFG   = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_STAT  = 8'h0c;
  localparam logic [7:0] OFS_RES_A = 8'h10;
  localparam logic [7:0] OFS_RES_B = 8'h14;
  localparam logic [7:0] OFS_CRC   = 8'h18;
  localparam logic [7:0] OFS_RDATA = 8'h1c;

  // Command bits in CTRL, status bits in STAT
  localparam int CTL_CONV  = 0;
  localparam int CTL_WREG  = 1;
  localparam int CTL_RREG  = 2;
  localparam int CTL_RESET = 3;
  localparam int STA_BUSY  = 0;
  localparam int STA_SW    = 1;
  localparam int STA_CRCON = 2;
  localparam int STA_ERR   = 3;
  localparam int STA_DONE  = 4;

  localparam logic [1:0] SW_MODE_CODE = 2'h0;
  localparam logic [7:0] CRC_INIT     = 8'h00;
  localparam int         STAT_CRC_LSB = 0;
  localparam logic [7:0] CFG_RESET    = 8'h00;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  typedef struct packed {
    logic [2:0] pairs_m1;
    logic       status_on;
    logic       crc_pin;
    logic       byte_sel;
    logic [1:0] range_sel;
  } prc_cfg_s;

  typedef struct packed {
    logic        reset_n;
    logic        cs_n;
    logic        rd_n;
    logic        wr_n;
    logic        conversion_start_in;
    logic [1:0]  range_mode_select_pins;
    logic        interface_select_pin;
    logic        byte_select_pin;
    logic        check_enable;
    logic        data_oe;
    logic [15:0] data_o;
  } prc_pins_s;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_RST     = 4'h1,
    ST_CONV    = 4'h2,
    ST_WAIT_HI = 4'h3,
    ST_WAIT_LO = 4'h4,
    ST_RD_LO   = 4'h5,
    ST_RD_HI   = 4'h6,
    ST_WR_LO   = 4'h7,
    ST_WR_HI   = 4'h8
  } prc_st_e;
endpackage

// ---- verilog/prc_host.sv ----
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns
// Notes on behaviour
// - Interface select pin held low for parallel; byte select sampled at release.
// - Conversion starts on start rising edge; reading waits for busy to fall.
// - Host does at least two reads per conversion, more with status or bursts.
// - Register write is one 16-bit access, latched on write strobe rising.
// - Host drives the register word on data lines while write strobe low.
// - Host recomputes CRC over received results and compares with received word.
// - Register read is a command write then a read strobe returning contents.
module prc_host
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic [7:0]        awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [7:0]        araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              busy_in,
  input  wire logic [15:0]       parallel_data_lines_i,
  output prc_pkg::prc_pins_s     pins
);

  function automatic logic [7:0] crc_out(input logic [15:0] d, input logic [7:0] c);
    logic [7:0] r;
    r[0] = d[14]^d[12]^d[8]^d[7]^d[6]^d[0]^c[0]^c[4]^c[6];
    r[1] = d[15]^d[14]^d[13]^d[12]^d[9]^d[6]^d[1]^d[0]^c[1]^c[4]^c[5]^c[6]^c[7];
    r[2] = d[15]^d[13]^d[12]^d[10]^d[8]^d[6]^d[2]^d[1]^d[0]^c[0]^c[2]^c[4]^c[5]^c[7];
    r[3] = d[14]^d[13]^d[11]^d[9]^d[7]^d[3]^d[2]^d[1]^c[1]^c[3]^c[5]^c[6];
    r[4] = d[15]^d[14]^d[12]^d[10]^d[8]^d[4]^d[3]^d[2]^c[0]^c[2]^c[4]^c[6]^c[7];
    r[5] = d[15]^d[13]^d[11]^d[9]^d[5]^d[4]^c[2]^c[4]^c[3]^c[5]^c[7];
    r[6] = d[14]^d[12]^d[10]^d[6]^d[5]^d[4]^c[2]^c[4]^c[6];
    r[7] = d[15]^d[13]^d[11]^d[7]^d[6]^d[5]^c[3]^c[5]^c[7];
    return r;
  endfunction

  prc_pkg::prc_st_e   st_q, st_d;
  prc_pkg::prc_cfg_s  cfg_q, cfg_d;
  prc_pkg::prc_pins_s pins_d;
  logic [7:0]  cnt_q, cnt_d;
  logic [4:0]  rd_idx_q, rd_idx_d;
  logic [4:0]  nrd_q, nrd_d;
  logic        reg_rd_q, reg_rd_d;
  logic        sw_mode_q, sw_mode_d;
  logic        crc_on_q, crc_on_d;
  logic        err_q, err_d;
  logic        done_q, done_d;
  logic [7:0]  crc_q, crc_d;
  logic [7:0]  crc_rx_q, crc_rx_d;
  logic [15:0] res_a_q, res_a_d;
  logic [15:0] res_b_q, res_b_d;
  logic [15:0] rdreg_q, rdreg_d;
  logic [15:0] word_q, word_d;
  logic        aw_have_q, aw_have_d;
  logic        w_have_q, w_have_d;
  logic [7:0]  aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0]  w_strb_q, w_strb_d;
  logic        bvalid_q, bvalid_d;
  logic [1:0]  bresp_q, bresp_d;
  logic        rvalid_q, rvalid_d;
  logic [1:0]  rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic        pin_reset_n_q, pin_reset_n_d;
  logic        pin_cs_n_q, pin_cs_n_d;
  logic        pin_rd_n_q, pin_rd_n_d;
  logic        pin_wr_n_q, pin_wr_n_d;
  logic        pin_conv_q, pin_conv_d;
  logic        pin_oe_q, pin_oe_d;

  // Ready only while frozen state can record the transfer
  assign awready = ce && !aw_have_q && !bvalid_q;
  assign wready  = ce && !w_have_q && !bvalid_q;
  assign arready = ce && !rvalid_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign rvalid  = rvalid_q;
  assign rresp   = rresp_q;
  assign rdata   = rdata_q;

  always_comb
  begin
    logic       go_conv;
    logic       go_wreg;
    logic       go_rreg;
    logic       go_rst;
    logic [4:0] n_words;
    logic       last_res;
    go_conv = 1'b0;
    go_wreg = 1'b0;
    go_rreg = 1'b0;
    go_rst  = 1'b0;
    n_words = 5'h0;
    last_res = 1'b0;
    st_d = st_q;
    cfg_d = cfg_q;
    cnt_d = cnt_q;
    rd_idx_d = rd_idx_q;
    nrd_d = nrd_q;
    reg_rd_d = reg_rd_q;
    sw_mode_d = sw_mode_q;
    crc_on_d = crc_on_q;
    err_d = err_q;
    done_d = done_q;
    crc_d = crc_q;
    crc_rx_d = crc_rx_q;
    res_a_d = res_a_q;
    res_b_d = res_b_q;
    rdreg_d = rdreg_q;
    word_d = word_q;
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    aw_addr_d = aw_addr_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;

    // Write channel; address and data may arrive in either order
    if (bvalid_q && bready)
      bvalid_d = 1'b0;
    if (awvalid && awready)
    begin
      aw_have_d = 1'b1;
      aw_addr_d = awaddr;
    end
    if (wvalid && wready)
    begin
      w_have_d = 1'b1;
      w_data_d = wdata;
      w_strb_d = wstrb;
    end
    if (aw_have_q && w_have_q)
    begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = prc_pkg::RESP_OKAY;
      unique case (aw_addr_q)
        prc_pkg::OFS_CTRL:
          // Commands while a sequence runs are dropped
          if (w_strb_q[0] && st_q == prc_pkg::ST_IDLE)
          begin
            go_rst  = w_data_q[prc_pkg::CTL_RESET];
            go_conv = w_data_q[prc_pkg::CTL_CONV];
            go_wreg = w_data_q[prc_pkg::CTL_WREG] && sw_mode_q;
            go_rreg = w_data_q[prc_pkg::CTL_RREG] && sw_mode_q;
          end
        prc_pkg::OFS_CFG:
          if (w_strb_q[0])
            cfg_d = w_data_q[7:0];
        prc_pkg::OFS_WDATA:
        begin
          if (w_strb_q[0])
            word_d[7:0] = w_data_q[7:0];
          if (w_strb_q[1])
            word_d[15:8] = w_data_q[15:8];
        end
        prc_pkg::OFS_STAT:
          if (w_strb_q[0])
          begin
            if (w_data_q[prc_pkg::STA_ERR])
              err_d = 1'b0;
            if (w_data_q[prc_pkg::STA_DONE])
              done_d = 1'b0;
          end
        prc_pkg::OFS_RES_A, prc_pkg::OFS_RES_B, prc_pkg::OFS_CRC, prc_pkg::OFS_RDATA: ;
        default:
          bresp_d = prc_pkg::RESP_SLVERR;
      endcase
    end

    // Read channel
    if (rvalid_q && rready)
      rvalid_d = 1'b0;
    if (arvalid && arready)
    begin
      rvalid_d = 1'b1;
      rresp_d = prc_pkg::RESP_OKAY;
      rdata_d = 32'h0;
      unique case (araddr)
        prc_pkg::OFS_CTRL:  rdata_d = 32'h0;
        prc_pkg::OFS_CFG:   rdata_d[7:0] = cfg_q;
        prc_pkg::OFS_WDATA: rdata_d[15:0] = word_q;
        prc_pkg::OFS_STAT:
        begin
          rdata_d[prc_pkg::STA_BUSY]  = (st_q != prc_pkg::ST_IDLE);
          rdata_d[prc_pkg::STA_SW]    = sw_mode_q;
          rdata_d[prc_pkg::STA_CRCON] = crc_on_q;
          rdata_d[prc_pkg::STA_ERR]   = err_q;
          rdata_d[prc_pkg::STA_DONE]  = done_q;
        end
        prc_pkg::OFS_RES_A: rdata_d[15:0] = res_a_q;
        prc_pkg::OFS_RES_B: rdata_d[15:0] = res_b_q;
        prc_pkg::OFS_CRC:   rdata_d[15:0] = {crc_rx_q, crc_q};
        prc_pkg::OFS_RDATA: rdata_d[15:0] = rdreg_q;
        default:            rresp_d = prc_pkg::RESP_SLVERR;
      endcase
    end

    // Pin sequencer; flags set after the software clear so a set wins
    n_words = 5'({cfg_q.pairs_m1, 1'b0}) + 5'h2;
    unique case (st_q)
      prc_pkg::ST_IDLE:
        if (go_rst)
        begin
          st_d = prc_pkg::ST_RST;
          cnt_d = 8'(prc_pkg::RESET_CYC - 1);
        end
        else if (go_conv)
        begin
          st_d = prc_pkg::ST_CONV;
          cnt_d = 8'(prc_pkg::STROBE_CYC - 1);
          crc_d = prc_pkg::CRC_INIT;
          rd_idx_d = 5'h0;
          reg_rd_d = 1'b0;
          nrd_d = n_words + 5'(crc_on_q);
        end
        else if (go_wreg || go_rreg)
        begin
          st_d = prc_pkg::ST_WR_LO;
          cnt_d = 8'(prc_pkg::STROBE_CYC - 1);
          reg_rd_d = go_rreg;
        end
      prc_pkg::ST_RST:
        if (cnt_q == 8'h0)
        begin
          st_d = prc_pkg::ST_IDLE;
          sw_mode_d = (cfg_q.range_sel == prc_pkg::SW_MODE_CODE);
          // Parallel hardware mode has no CRC word at all
          crc_on_d = (cfg_q.range_sel == prc_pkg::SW_MODE_CODE) && cfg_q.status_on;
        end
        else
          cnt_d = cnt_q - 8'h1;
      prc_pkg::ST_CONV:
        if (cnt_q == 8'h0)
          st_d = prc_pkg::ST_WAIT_HI;
        else
          cnt_d = cnt_q - 8'h1;
      prc_pkg::ST_WAIT_HI:
        // Busy that never rises leaves us waiting; only aresetn recovers, as the reset command is dropped outside ST_IDLE
        if (busy_in)
          st_d = prc_pkg::ST_WAIT_LO;
      prc_pkg::ST_WAIT_LO:
        if (!busy_in)
        begin
          st_d = prc_pkg::ST_RD_LO;
          cnt_d = 8'(prc_pkg::STROBE_CYC - 1);
        end
      prc_pkg::ST_RD_LO:
        if (cnt_q == 8'h0)
        begin
          st_d = prc_pkg::ST_RD_HI;
          cnt_d = 8'(prc_pkg::STROBE_CYC - 1);
          last_res = (rd_idx_q < n_words);
          if (reg_rd_q)
            rdreg_d = parallel_data_lines_i;
          else if (last_res && !rd_idx_q[0])
          begin
            res_a_d = parallel_data_lines_i;
            crc_d = crc_out(parallel_data_lines_i, crc_q);
          end
          else if (last_res)
          begin
            res_b_d = parallel_data_lines_i;
            crc_d = crc_out(parallel_data_lines_i, crc_q);
          end
          else
          begin
            crc_rx_d = parallel_data_lines_i[prc_pkg::STAT_CRC_LSB +: 8];
            if (crc_rx_d != crc_q)
              err_d = 1'b1;
          end
        end
        else
          cnt_d = cnt_q - 8'h1;
      prc_pkg::ST_RD_HI:
        if (cnt_q == 8'h0)
        begin
          if (rd_idx_q == nrd_q - 5'h1)
          begin
            st_d = prc_pkg::ST_IDLE;
            done_d = 1'b1;
          end
          else
          begin
            rd_idx_d = rd_idx_q + 5'h1;
            st_d = prc_pkg::ST_RD_LO;
            cnt_d = 8'(prc_pkg::STROBE_CYC - 1);
          end
        end
        else
          cnt_d = cnt_q - 8'h1;
      prc_pkg::ST_WR_LO:
        if (cnt_q == 8'h0)
        begin
          st_d = prc_pkg::ST_WR_HI;
          cnt_d = 8'(prc_pkg::STROBE_CYC - 1);
        end
        else
          cnt_d = cnt_q - 8'h1;
      prc_pkg::ST_WR_HI:
        if (cnt_q == 8'h0)
        begin
          if (reg_rd_q)
          begin
            st_d = prc_pkg::ST_RD_LO;
            cnt_d = 8'(prc_pkg::STROBE_CYC - 1);
            rd_idx_d = 5'h0;
            nrd_d = 5'h1;
          end
          else
          begin
            st_d = prc_pkg::ST_IDLE;
            done_d = 1'b1;
          end
        end
        else
          cnt_d = cnt_q - 8'h1;
      default:
        st_d = prc_pkg::ST_IDLE;
    endcase

    // Pins follow the next state so strobes come straight from flops
    pin_reset_n_d = (st_d != prc_pkg::ST_RST);
    pin_conv_d = (st_d == prc_pkg::ST_CONV);
    pin_cs_n_d = !(st_d inside {prc_pkg::ST_RD_LO, prc_pkg::ST_RD_HI,
                               prc_pkg::ST_WR_LO, prc_pkg::ST_WR_HI});
    pin_rd_n_d = (st_d != prc_pkg::ST_RD_LO);
    pin_wr_n_d = (st_d != prc_pkg::ST_WR_LO);
    // Drive held through the high phase to cover the latch edge
    pin_oe_d = (st_d == prc_pkg::ST_WR_LO) || (st_d == prc_pkg::ST_WR_HI);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // Boot issues a full device reset so the mode pins are sampled
      st_q <= prc_pkg::ST_RST;
      cfg_q <= prc_pkg::CFG_RESET;
      cnt_q <= 8'(prc_pkg::RESET_CYC - 1);
      rd_idx_q <= 5'h0;
      nrd_q <= 5'h0;
      reg_rd_q <= 1'b0;
      sw_mode_q <= 1'b0;
      crc_on_q <= 1'b0;
      err_q <= 1'b0;
      done_q <= 1'b0;
      crc_q <= prc_pkg::CRC_INIT;
      crc_rx_q <= 8'h00;
      res_a_q <= 16'h0000;
      res_b_q <= 16'h0000;
      rdreg_q <= 16'h0000;
      word_q <= 16'h0000;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= prc_pkg::RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= prc_pkg::RESP_OKAY;
      rdata_q <= 32'h0;
      pin_reset_n_q <= 1'b0;
      pin_cs_n_q <= 1'b1;
      pin_rd_n_q <= 1'b1;
      pin_wr_n_q <= 1'b1;
      pin_conv_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end
    else if (ce)
    begin
      st_q <= st_d;
      cfg_q <= cfg_d;
      cnt_q <= cnt_d;
      rd_idx_q <= rd_idx_d;
      nrd_q <= nrd_d;
      reg_rd_q <= reg_rd_d;
      sw_mode_q <= sw_mode_d;
      crc_on_q <= crc_on_d;
      err_q <= err_d;
      done_q <= done_d;
      crc_q <= crc_d;
      crc_rx_q <= crc_rx_d;
      res_a_q <= res_a_d;
      res_b_q <= res_b_d;
      rdreg_q <= rdreg_d;
      word_q <= word_d;
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      aw_addr_q <= aw_addr_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      pin_reset_n_q <= pin_reset_n_d;
      pin_cs_n_q <= pin_cs_n_d;
      pin_rd_n_q <= pin_rd_n_d;
      pin_wr_n_q <= pin_wr_n_d;
      pin_conv_q <= pin_conv_d;
      pin_oe_q <= pin_oe_d;
    end
  end

  always_comb
  begin
    pins_d = '0;
    pins_d.reset_n = pin_reset_n_q;
    pins_d.cs_n = pin_cs_n_q;
    pins_d.rd_n = pin_rd_n_q;
    pins_d.wr_n = pin_wr_n_q;
    pins_d.conversion_start_in = pin_conv_q;
    pins_d.range_mode_select_pins = cfg_q.range_sel;
    pins_d.interface_select_pin = 1'b0;
    pins_d.byte_select_pin = cfg_q.byte_sel;
    pins_d.check_enable = cfg_q.crc_pin;
    pins_d.data_oe = pin_oe_q;
    pins_d.data_o = word_q;
  end
  assign pins = pins_d;

endmodule

// ---- verif/prc_host_properties.sv ----
`timescale 1ns/1ns
module prc_host_props
(
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               arvalid,
  input wire logic               arready,
  input wire logic               rvalid,
  input wire logic               busy_in,
  input wire prc_pkg::prc_pins_s pins
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_oe_cs_only: assert property (pins.data_oe |-> !pins.cs_n && pins.rd_n)
    else $error("host drives data lines outside a write");
  a_wr_oe_held: assert property (!pins.wr_n |-> pins.data_oe && !pins.cs_n)
    else $error("write strobe low without host drive");
  a_wr_rise_data: assert property ($rose(pins.wr_n) |-> pins.data_oe && $stable(pins.data_o))
    else $error("write word not held at write strobe rise");
  a_rd_pulse_len: assert property ($fell(pins.rd_n) |-> (!pins.rd_n && !pins.cs_n)[*3] ##1 pins.rd_n)
    else $error("read strobe pulse wrong");
  a_rd_not_busy: assert property ($fell(pins.rd_n) |-> !busy_in)
    else $error("read started during conversion");
  a_conv_pulse: assert property ($rose(pins.conversion_start_in) |->
    pins.conversion_start_in[*3] ##1 !pins.conversion_start_in)
    else $error("start pulse length wrong");
  a_release_mode: assert property ($rose(pins.reset_n) |-> $stable(pins.range_mode_select_pins)
    && !$past(pins.reset_n, 10) && !pins.interface_select_pin)
    else $error("mode pins moved at reset release");
  a_cs_after_busy: assert property ($fell(busy_in) |-> ##[1:2] (!pins.cs_n && !pins.rd_n))
    else $error("readout not started after busy fell");
  a_ar_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");

  c_conv: cover property ($rose(pins.conversion_start_in));
  c_read: cover property ($fell(pins.rd_n));
  c_write: cover property ($rose(pins.wr_n));
endmodule

bind prc_host prc_host_props chk_u (.aclk(aclk), .aresetn(aresetn), .arvalid(arvalid),
  .arready(arready), .rvalid(rvalid), .busy_in(busy_in), .pins(pins));

// ---- verif/prc_dev_model.sv ----
`timescale 1ns/1ns
module prc_dev_model
#(
  parameter int          CONV_CYC = 20,
  parameter logic [15:0] A_BASE   = 16'h1234,
  parameter logic [15:0] B_BASE   = 16'hc3a5,
  parameter logic [15:0] MON_CODE = 16'h7e01
)
(
  input  wire logic               aclk,
  input  wire prc_pkg::prc_pins_s pins,
  output logic                    busy,
  output logic [15:0]             dq
);
  logic        sw, hw_crc, crc_en, stest, mon, regrd, bad_crc, conv_q, wr_q, rd_q, b;
  logic [15:0] word, res;
  logic [7:0]  crc;
  int          cnt, idx;

  function automatic logic [7:0] crc_f(input logic [15:0] d, input logic [7:0] c);
    logic [15:0] dm [8];
    logic [7:0]  cm [8];
    logic [7:0]  o;
    dm = '{16'h51c1, 16'hf243, 16'hb547, 16'h6a8e, 16'hd51c, 16'haa30, 16'h5470, 16'ha8e0};
    cm = '{8'h51, 8'hf2, 8'hb5, 8'h6a, 8'hd5, 8'hbc, 8'h54, 8'ha8};
    for (int i = 0; i < 8; i++)
      o[i] = (^(d & dm[i])) ^ (^(c & cm[i]));
    return o;
  endfunction

  initial
  begin
    {bad_crc, busy, b, conv_q} = 4'h0;
    {wr_q, rd_q} = 2'h3;
    dq = 16'h0000;
  end

  always @(posedge aclk)
  begin
    if (!pins.reset_n)
    begin
      sw = (pins.range_mode_select_pins == 2'h0);
      // Parallel hardware operation never carries a check word
      hw_crc = pins.check_enable & ~sw & pins.interface_select_pin;
      {stest, mon, regrd, b} = 4'h0;
      crc_en = hw_crc;
      idx = 0;
    end
    else
    begin
      if (pins.conversion_start_in && !conv_q)
      begin
        b = 1'b1;
        cnt = CONV_CYC;
        idx = 0;
        regrd = 1'b0;
        crc = 8'h00;
      end
      else if (b)
      begin
        cnt--;
        if (cnt == 0)
          b = 1'b0;
      end
      if (!pins.cs_n && !pins.rd_n && rd_q)
      begin
        if (regrd)
          res = word;
        else if (crc_en && idx == 2)
          res = {8'h00, crc ^ {7'h00, bad_crc}};
        else
        begin
          if (stest)
            res = idx[0] ? 16'h5555 : 16'haaaa;
          else if (mon)
            res = MON_CODE;
          else
            res = (idx[0] ? B_BASE : A_BASE) + 16'(idx / 2);
          // Chained over what was actually served
          crc = crc_f(res, crc);
        end
        idx++;
      end
      // Registers reachable only in software mode
      if (pins.wr_n && !wr_q && !pins.cs_n && sw)
      begin
        word = pins.data_o;
        regrd = 1'b1;
        if (word[15:12] == 4'h2)
          crc_en = |word[1:0];
        if (word[15:12] == 4'h3)
        begin
          stest = (word[3:0] == 4'hb);
          mon = (word[3:0] == 4'h8) || (word[3:0] == 4'h9);
        end
      end
    end
    conv_q = pins.conversion_start_in;
    wr_q = pins.wr_n;
    rd_q = pins.rd_n;
    busy <= b;
    if (!pins.cs_n && !pins.rd_n)
      dq <= res;
    else if (pins.data_oe)
      dq <= pins.data_o;
    else
      dq <= ~dq;
  end
endmodule

// ---- verif/test_parallel_readout_crc_port.sv ----
`timescale 1ns/1ns
module test_parallel_readout_crc_port;
  localparam logic [15:0] VA = 16'h1234;
  localparam logic [15:0] VB = 16'hc3a5;
  localparam logic [15:0] VM = 16'h7e01;
  logic               aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic               arvalid, arready, rvalid, rready, busy_in;
  logic [7:0]         awaddr, araddr;
  logic [31:0]        wdata, rdata;
  logic [3:0]         wstrb;
  logic [1:0]         bresp, rresp;
  logic [15:0]        dq;
  logic [7:0]         c;
  prc_pkg::prc_pins_s pins;
  int                 fail_count, n_checks;

  always #5 aclk = ~aclk;

  prc_host dut_u (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .busy_in(busy_in), .parallel_data_lines_i(dq), .pins(pins));
  prc_dev_model #(.A_BASE(VA), .B_BASE(VB), .MON_CODE(VM)) dev_u (.aclk(aclk), .pins(pins),
    .busy(busy_in), .dq(dq));

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    {awaddr, wdata, wstrb} <= {a, d, 4'hf};
    {awvalid, wvalid, bready} <= 3'h7;
    for (n = 0; n < 50 && bvalid !== 1'b1; n++)
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    if (n == 50)
    begin
      fail_count++;
      final_report();
    end
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    for (n = 0; n < 50 && rvalid !== 1'b1; n++)
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    if (n == 50)
    begin
      fail_count++;
      final_report();
    end
    {d, r} = {rdata, rresp};
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chk(32'(r), 32'(prc_pkg::RESP_OKAY));
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axr(a, d, r);
    chk(d & m, e);
  endtask

  // Polls status; a stuck device ends the run here
  task automatic wait_stat(input int b, input logic v);
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    for (n = 0; n < 100; n++)
    begin
      axr(prc_pkg::OFS_STAT, d, r);
      if (d[b] === v)
        break;
    end
    if (n == 100)
    begin
      chk(d, 32'(v) << b);
      final_report();
    end
  endtask

  task automatic cmd(input logic [31:0] bits);
    wr(prc_pkg::OFS_CTRL, bits);
    wait_stat(prc_pkg::STA_DONE, 1'b1);
    wr(prc_pkg::OFS_STAT, 32'h10);
  endtask

  task automatic dev_reset(input logic [31:0] cfg);
    wr(prc_pkg::OFS_CFG, cfg);
    wr(prc_pkg::OFS_CTRL, 32'h8);
    wait_stat(prc_pkg::STA_BUSY, 1'b1);
    wait_stat(prc_pkg::STA_BUSY, 1'b0);
  endtask

  task automatic conv(input logic [15:0] a, input logic [15:0] b, input logic [7:0] k);
    cmd(32'h1);
    rdc(prc_pkg::OFS_RES_A, 32'hffff, 32'(a));
    rdc(prc_pkg::OFS_RES_B, 32'hffff, 32'(b));
    rdc(prc_pkg::OFS_CRC, 32'hffff, {16'h0, k, k});
  endtask

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    rdc(prc_pkg::OFS_CFG, 32'hffffffff, 32'h0);
    rdc(prc_pkg::OFS_STAT, 32'h7, 32'h2);
    axr(8'h40, d, r);
    chk({d[29:0], r}, {30'h0, prc_pkg::RESP_SLVERR});
    axw(8'h40, 32'h1, r);
    chk(32'(r), 32'(prc_pkg::RESP_SLVERR));
  endtask

  task automatic t_sw_crc();
    dev_reset(32'h10);
    rdc(prc_pkg::OFS_STAT, 32'h6, 32'h6);
    wr(prc_pkg::OFS_WDATA, 32'h2001);
    cmd(32'h2);
    c = dev_u.crc_f(VB, dev_u.crc_f(VA, 8'h00));
    conv(VA, VB, c);
    rdc(prc_pkg::OFS_STAT, 32'h8, 32'h0);
  endtask

  task automatic t_self_test();
    wr(prc_pkg::OFS_WDATA, 32'h300b);
    cmd(32'h2);
    c = dev_u.crc_f(16'h5555, dev_u.crc_f(16'haaaa, 8'h00));
    conv(16'haaaa, 16'h5555, c);
    dev_u.bad_crc = 1'b1;
    cmd(32'h1);
    rdc(prc_pkg::OFS_STAT, 32'h8, 32'h8);
    dev_u.bad_crc = 1'b0;
    wr(prc_pkg::OFS_STAT, 32'h8);
    rdc(prc_pkg::OFS_STAT, 32'h8, 32'h0);
    wr(prc_pkg::OFS_WDATA, 32'h1234);
    cmd(32'h4);
    rdc(prc_pkg::OFS_RDATA, 32'hffff, 32'h1234);
    wr(prc_pkg::OFS_WDATA, 32'h3008);
    cmd(32'h2);
    c = dev_u.crc_f(VM, dev_u.crc_f(VM, 8'h00));
    conv(VM, VM, c);
  endtask

  task automatic t_hw();
    dev_reset(32'h39);
    rdc(prc_pkg::OFS_STAT, 32'h6, 32'h0);
    cmd(32'h1);
    rdc(prc_pkg::OFS_RES_A, 32'hffff, 32'(VA + 16'h1));
    rdc(prc_pkg::OFS_RES_B, 32'hffff, 32'(VB + 16'h1));
  endtask

  initial
  begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    {fail_count, n_checks} = 64'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    wait_stat(prc_pkg::STA_BUSY, 1'b0);
    t_regs();
    t_sw_crc();
    t_self_test();
    t_hw();
    final_report();
  end
endmodule
